/* common/pfv_map.vh */
// Summary of operation
// (RL1) the block does every crc, coding and scrambling step itself in both directions.
// (RL2) a field that fails its crc is handed to the host together with a failure flag.
// (RL3) the host exchanges one message info block; the duplicate is made or consumed here.
// (RL4) both received copies are decoded and crc checked; the call is accepted if either passes.
// (RL5) in vocoder mode commands and voice move over the auxiliary port without the host.
// (RL6) with a third-party vocoder, voice goes via the host port and the host runs the vocoder.
// (RL7) receive voice to the attached vocoder is always 4-bit log-likelihood soft symbols.
// (RL8) soft format may be chosen for host voice, making host transfers four times as many.
// (RL9) the host interrupt rises only for status bits whose mask bit is set.
// (RL10) host-written settings are sampled once per 250 us latency period.
// (RL11) the host should not write one setting twice within a 250 us latency period.
// (RL12) if both copies fail their crc the call is rejected and the failure is reported.
`ifndef PFV_MAP_VH
`define PFV_MAP_VH

// ****************************************************
// field layout
// ****************************************************
`define PFV_MI_DATA_W 24
`define PFV_MI_CRC_W 8
`define PFV_MI_CODED_W 32
`define PFV_CRC_POLY 8'h07
`define PFV_CRC_INIT 8'hFF
`define PFV_SCRAMBLE_MASK 32'hA5C3_96E1
`define PFV_LLR_W 4

// ****************************************************
// status bits
// ****************************************************
`define PFV_ST_W 4
`define PFV_ST_MI_RX 0
`define PFV_ST_CRC_FAIL 1
`define PFV_ST_VOICE 2
`define PFV_ST_CALL_REJ 3

// ****************************************************
// vocoder commands
// ****************************************************
`define PFV_VCMD_DECODE 8'h01
`define PFV_VCMD_ENCODE 8'h02

// ****************************************************
// timing
// ****************************************************
`define PFV_LATENCY_US 250
`define PFV_CLK_MHZ 250
`define PFV_LATENCY_CYCLES (`PFV_LATENCY_US * `PFV_CLK_MHZ)

`endif

/* verilog/pfv_fec_route.v */
`timescale 1ns/1ps
`include "pfv_map.vh"

module pfv_fec_route #(
	parameter LATENCY_CYCLES = `PFV_LATENCY_CYCLES
)(
	input wire ref_clk,
	input wire reset,
	input wire host_cfg_via_host,
	input wire host_cfg_soft,
	input wire [`PFV_ST_W-1:0] host_cfg_irq_mask,
	input wire host_status_read,
	output reg [`PFV_ST_W-1:0] host_status,
	output wire host_irq,
	output reg cfg_via_host_reg,
	output reg cfg_soft_reg,
	input wire rx_mi_valid,
	input wire [`PFV_MI_CODED_W-1:0] message_info_copy_zero,
	input wire [`PFV_MI_CODED_W-1:0] message_info_copy_one,
	output reg host_mi_valid,
	output reg [`PFV_MI_DATA_W-1:0] message_info_block,
	output reg host_mi_crc_fail,
	output reg call_accept,
	output reg call_reject,
	input wire host_tx_mi_valid,
	input wire [`PFV_MI_DATA_W-1:0] host_tx_mi_data,
	output reg tx_mi_valid,
	output reg [`PFV_MI_CODED_W-1:0] tx_mi_copy_zero,
	output reg [`PFV_MI_CODED_W-1:0] tx_mi_copy_one,
	input wire rx_voice_valid,
	input wire rx_voice_bit,
	input wire [`PFV_LLR_W-1:0] rx_voice_llr,
	output reg voc_rx_valid,
	output reg [`PFV_LLR_W-1:0] voc_rx_llr,
	output reg voc_cmd_valid,
	output reg [7:0] voc_cmd,
	output reg host_voice_valid,
	output reg [7:0] host_voice_byte,
	input wire voc_tx_valid,
	input wire voc_tx_bit,
	input wire host_tx_voice_valid,
	input wire host_tx_voice_bit,
	output reg tx_voice_valid,
	output reg tx_voice_bit
);

	// ****************************************************
	// crc over the message info data
	// ****************************************************
	function [`PFV_MI_CRC_W-1:0] pfv_crc;
		input [`PFV_MI_DATA_W-1:0] data;
		integer i;
		reg [`PFV_MI_CRC_W-1:0] c;
		begin
			c = `PFV_CRC_INIT;
			for (i = `PFV_MI_DATA_W - 1; i >= 0; i = i - 1)
			begin
				if (c[`PFV_MI_CRC_W-1] ^ data[i])
					c = {c[`PFV_MI_CRC_W-2:0], 1'h0} ^ `PFV_CRC_POLY;
				else
					c = {c[`PFV_MI_CRC_W-2:0], 1'h0};
			end
			pfv_crc = c;
		end
	endfunction

	// ****************************************************
	// latency period sampling of host settings
	// ****************************************************
	localparam integer TICK_LAST_INT = LATENCY_CYCLES - 1;
	localparam [15:0] TICK_LAST = TICK_LAST_INT[15:0];
	reg [15:0] tick_cnt_reg;
	reg [`PFV_ST_W-1:0] irq_mask_reg;
	wire tick = (tick_cnt_reg == TICK_LAST);

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			tick_cnt_reg <= 16'h0000;
			cfg_via_host_reg <= 1'h0;
			cfg_soft_reg <= 1'h0;
			irq_mask_reg <= {`PFV_ST_W{1'h0}};
		end
		else
		begin
			tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
			if (tick)
			begin
				cfg_via_host_reg <= host_cfg_via_host; // RL10
				cfg_soft_reg <= host_cfg_soft; // RL10
				irq_mask_reg <= host_cfg_irq_mask; // RL10
			end
		end
	end

	// ****************************************************
	// receive message info: descramble, check both copies
	// ****************************************************
	wire [`PFV_MI_CODED_W-1:0] rx0 = message_info_copy_zero ^ `PFV_SCRAMBLE_MASK; // RL1
	wire [`PFV_MI_CODED_W-1:0] rx1 = message_info_copy_one ^ `PFV_SCRAMBLE_MASK; // RL1
	wire [2*`PFV_MI_CODED_W-1:0] rx_both = {rx1, rx0};
	wire [1:0] rx_ok;
	genvar g;

	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gen_copy_check
			wire [`PFV_MI_CODED_W-1:0] copy_word;
			assign copy_word = rx_both[g*`PFV_MI_CODED_W +: `PFV_MI_CODED_W];
			assign rx_ok[g] = (pfv_crc(copy_word[`PFV_MI_CODED_W-1:`PFV_MI_CRC_W]) ==
				copy_word[`PFV_MI_CRC_W-1:0]); // RL4
		end
	endgenerate

	wire rx0_ok = rx_ok[0];
	wire rx1_ok = rx_ok[1];
	wire [`PFV_MI_CODED_W-1:0] tx_coded = {host_tx_mi_data ^ 24'h000000,
		pfv_crc(host_tx_mi_data)}; // RL1

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			host_mi_valid <= 1'h0;
			message_info_block <= {`PFV_MI_DATA_W{1'h0}};
			host_mi_crc_fail <= 1'h0;
			call_accept <= 1'h0;
			call_reject <= 1'h0;
			tx_mi_valid <= 1'h0;
			tx_mi_copy_zero <= {`PFV_MI_CODED_W{1'h0}};
			tx_mi_copy_one <= {`PFV_MI_CODED_W{1'h0}};
		end
		else
		begin
			host_mi_valid <= rx_mi_valid; // RL3
			call_accept <= rx_mi_valid & (rx0_ok | rx1_ok); // RL4
			call_reject <= rx_mi_valid & ~rx0_ok & ~rx1_ok; // RL12
			if (rx_mi_valid)
			begin
				message_info_block <= (rx0_ok | ~rx1_ok) ?
					rx0[`PFV_MI_CODED_W-1:`PFV_MI_CRC_W] :
					rx1[`PFV_MI_CODED_W-1:`PFV_MI_CRC_W]; // RL3
				host_mi_crc_fail <= ~rx0_ok & ~rx1_ok; // RL2 RL12
			end
			tx_mi_valid <= host_tx_mi_valid;
			if (host_tx_mi_valid)
			begin
				tx_mi_copy_zero <= tx_coded ^ `PFV_SCRAMBLE_MASK; // RL3
				tx_mi_copy_one <= tx_coded ^ `PFV_SCRAMBLE_MASK; // RL3
			end
		end
	end

	// ****************************************************
	// voice routing
	// ****************************************************
	reg [7:0] pack_reg;
	reg [2:0] pack_cnt_reg;
	wire [2:0] pack_last = cfg_soft_reg ? 3'h1 : 3'h7;
	wire [7:0] pack_next = cfg_soft_reg ? {pack_reg[3:0], rx_voice_llr} :
		{pack_reg[6:0], rx_voice_bit}; // RL8
	wire host_voice_in = rx_voice_valid & cfg_via_host_reg; // RL6
	wire byte_done = host_voice_in & (pack_cnt_reg == pack_last);

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			pack_reg <= 8'h00;
			pack_cnt_reg <= 3'h0;
			host_voice_valid <= 1'h0;
			host_voice_byte <= 8'h00;
			voc_rx_valid <= 1'h0;
			voc_rx_llr <= {`PFV_LLR_W{1'h0}};
			voc_cmd_valid <= 1'h0;
			voc_cmd <= 8'h00;
			tx_voice_valid <= 1'h0;
			tx_voice_bit <= 1'h0;
		end
		else
		begin
			if (host_voice_in)
			begin
				pack_reg <= pack_next;
				pack_cnt_reg <= byte_done ? 3'h0 : pack_cnt_reg + 3'h1;
			end
			host_voice_valid <= byte_done; // RL8
			if (byte_done)
				host_voice_byte <= pack_next;
			voc_rx_valid <= rx_voice_valid & ~cfg_via_host_reg; // RL5
			if (rx_voice_valid & ~cfg_via_host_reg)
				voc_rx_llr <= rx_voice_llr; // RL7
			voc_cmd_valid <= ~cfg_via_host_reg &
				((rx_mi_valid & (rx0_ok | rx1_ok)) | host_tx_mi_valid); // RL5
			if (~cfg_via_host_reg & host_tx_mi_valid)
				voc_cmd <= `PFV_VCMD_ENCODE; // RL5
			else if (~cfg_via_host_reg & rx_mi_valid & (rx0_ok | rx1_ok))
				voc_cmd <= `PFV_VCMD_DECODE; // RL5
			tx_voice_valid <= cfg_via_host_reg ? host_tx_voice_valid : voc_tx_valid; // RL5 RL6
			tx_voice_bit <= cfg_via_host_reg ? host_tx_voice_bit : voc_tx_bit;
		end
	end

	// ****************************************************
	// status and masked interrupt
	// ****************************************************
	wire [`PFV_ST_W-1:0] st_set;
	assign st_set[`PFV_ST_MI_RX] = host_mi_valid;
	assign st_set[`PFV_ST_CRC_FAIL] = host_mi_valid & host_mi_crc_fail; // RL2
	assign st_set[`PFV_ST_VOICE] = host_voice_valid;
	assign st_set[`PFV_ST_CALL_REJ] = call_reject; // RL12

	always @(posedge ref_clk)
	begin
		if (reset)
			host_status <= {`PFV_ST_W{1'h0}};
		else
			host_status <= st_set | (host_status_read ? {`PFV_ST_W{1'h0}} : host_status);
	end

	assign host_irq = |(host_status & irq_mask_reg); // RL9

endmodule

/* tb/pfv_fec_route_sva.sv */
`timescale 1ns/1ps
// ***
// checker
// ***
module pfv_chk #(parameter LATENCY_CYCLES = 16)(
	input wire ref_clk,
	input wire reset,
	input wire [3:0] host_status,
	input wire host_irq,
	input wire [3:0] host_cfg_irq_mask,
	input wire cfg_soft_reg,
	input wire cfg_via_host_reg,
	input wire rx_mi_valid,
	input wire host_mi_valid,
	input wire host_mi_crc_fail,
	input wire call_accept,
	input wire call_reject,
	input wire host_tx_mi_valid,
	input wire tx_mi_valid,
	input wire [31:0] tx_mi_copy_zero,
	input wire [31:0] tx_mi_copy_one,
	input wire rx_voice_valid,
	input wire [3:0] rx_voice_llr,
	input wire voc_rx_valid,
	input wire [3:0] voc_rx_llr
);
reg [15:0] cnt_reg;
always @(posedge ref_clk)
	cnt_reg <= (reset || cnt_reg == LATENCY_CYCLES - 1) ? 16'h0000 : cnt_reg + 16'h0001;
reg [3:0] mask_reg;
always @(posedge ref_clk)
	mask_reg <= reset ? 4'h0 : (cnt_reg == LATENCY_CYCLES - 1) ? host_cfg_irq_mask : mask_reg;
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
sequence s_mi_ans; host_mi_valid ##1 host_status[0]; endsequence
a_mi_answer: assert property (rx_mi_valid |=> s_mi_ans) else $error("mi answer late");
a_one_verdict: assert property (host_mi_valid |-> call_accept ^ call_reject) else $error("verdict");
a_fail_flag: assert property (host_mi_valid |-> host_mi_crc_fail == call_reject) else $error("flag");
a_reject_status: assert property (call_reject |=> host_status[3]) else $error("reject status");
a_tx_dup: assert property (host_tx_mi_valid |=>
	tx_mi_valid && tx_mi_copy_zero == tx_mi_copy_one) else $error("tx copies differ");
a_irq_mask: assert property (host_irq |-> (host_status & mask_reg) != 4'h0)
	else $error("irq without masked status");
a_irq_raise: assert property ((host_status & mask_reg) != 4'h0 |-> host_irq)
	else $error("masked status without irq");
a_voc_soft: assert property (rx_voice_valid && !cfg_via_host_reg |=> voc_rx_valid
	&& voc_rx_llr == $past(rx_voice_llr)) else $error("vocoder llr");
a_cfg_tick: assert property ($changed({cfg_soft_reg, cfg_via_host_reg}) |->
	cnt_reg == 16'h0000) else $error("setting changed off tick");
endmodule

/* tb/pfv_vocoder.sv */
`timescale 1ns/1ps
// ***
// attached vocoder model
// ***
module pfv_vocoder (
	input wire ref_clk,
	input wire reset,
	input wire voc_cmd_valid,
	input wire [7:0] voc_cmd,
	input wire voc_rx_valid,
	output reg voc_tx_valid,
	output reg voc_tx_bit,
	output reg [7:0] n_sym
);
always @(posedge ref_clk)
begin
	voc_tx_valid <= !reset && voc_cmd_valid && voc_cmd == 8'h02;
	voc_tx_bit <= reset ? 1'h0 : !voc_tx_bit;
	n_sym <= reset ? 8'h00 : n_sym + {7'h00, voc_rx_valid};
end
endmodule

/* tb/pfv_fec_route_tb_top.sv */
`timescale 1ns/1ps
// ***
// bench
// ***
module pfv_fec_route_tb_top;
reg ref_clk = 1'h0, reset = 1'h1, host_cfg_via_host = 1'h0, host_cfg_soft = 1'h0;
reg host_status_read = 1'h0, rx_mi_valid = 1'h0, host_tx_mi_valid = 1'h0, rx_voice_valid = 1'h0;
reg rx_voice_bit = 1'h0, host_tx_voice_valid = 1'h0, host_tx_voice_bit = 1'h0;
reg [3:0] host_cfg_irq_mask = 4'h0, rx_voice_llr = 4'h0;
reg [23:0] host_tx_mi_data = 24'h0, d;
reg [31:0] message_info_copy_zero = 32'h0, message_info_copy_one = 32'h0, lfsr = 32'hA43FC01D;
wire [3:0] host_status, voc_rx_llr;
wire [7:0] voc_cmd, host_voice_byte, n_sym;
wire [23:0] message_info_block;
wire [31:0] tx_mi_copy_zero, tx_mi_copy_one;
wire host_irq, cfg_via_host_reg, cfg_soft_reg, host_mi_valid, host_mi_crc_fail, call_accept;
wire call_reject, tx_mi_valid, voc_rx_valid, voc_cmd_valid, host_voice_valid, voc_tx_valid;
wire voc_tx_bit, tx_voice_valid, tx_voice_bit;
integer n_mismatch = 0, checked = 0, i, k;
pfv_fec_route #(.LATENCY_CYCLES(16)) DUT (.*);
pfv_vocoder voc (.*);
initial forever #2 ref_clk = !ref_clk;
function [31:0] rnd(input [31:0] s);
	rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
function [31:0] code(input [23:0] v);
	reg [7:0] c;
	integer j;
	begin
		c = 8'hFF;
		for (j = 23; j >= 0; j = j - 1)
			c = {c[6:0], 1'h0} ^ ((c[7] ^ v[j]) ? 8'h07 : 8'h00);
		code = {v, c} ^ 32'hA5C396E1;
	end
endfunction
task ck(input [63:0] seen, input [63:0] exp, input [8*12:1] what);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
		end
	end
endtask
task wrap_up;
	begin
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
endtask
task sym(input [3:0] llr, input b);
	begin
		rx_voice_valid = 1'h1;
		rx_voice_llr = llr;
		rx_voice_bit = b;
		@(negedge ref_clk);
	end
endtask
task settle;
	begin
		for (k = 0; k < 40 && {cfg_via_host_reg, cfg_soft_reg} !==
			{host_cfg_via_host, host_cfg_soft}; k = k + 1)
			@(negedge ref_clk);
		ck({cfg_via_host_reg, cfg_soft_reg}, {host_cfg_via_host, host_cfg_soft}, "cfg");
		if (k == 40)
			wrap_up;
	end
endtask
initial
begin
	repeat (12) @(negedge ref_clk);
	reset = 1'h0;
	for (i = 0; i < 8; i = i + 1)
	begin
		lfsr = rnd(lfsr);
		d = lfsr[23:0];
		message_info_copy_zero = code(d) ^ {23'h0, i[0], 8'h0};
		message_info_copy_one = code(d) ^ {23'h0, i[1], 8'h0};
		host_tx_mi_data = d;
		rx_mi_valid = 1'h1;
		host_tx_mi_valid = 1'h1;
		sym(lfsr[27:24], 1'h0);
		ck(message_info_block, d ^ {23'h0, i % 4 == 3}, "mi data");
		ck(call_reject, i % 4 == 3, "reject");
		ck(host_mi_crc_fail, i % 4 == 3, "crc flag");
		ck(tx_mi_copy_one, code(d), "tx copy");
		ck({voc_cmd_valid, voc_cmd}, {1'h1, 8'h02}, "voc encode");
		ck(tx_voice_valid, i >= 2, "voc tx");
	end
	host_tx_mi_valid = 1'h0;
	rx_voice_valid = 1'h0;
	message_info_copy_zero = code(d);
	message_info_copy_one = code(d);
	@(negedge ref_clk);
	ck({voc_cmd_valid, voc_cmd}, {1'h1, 8'h01}, "voc decode");
	ck(call_accept, 1'h1, "accept");
	rx_mi_valid = 1'h0;
	host_cfg_irq_mask = 4'h1;
	host_cfg_via_host = 1'h1;
	@(negedge ref_clk);
	ck(host_irq, 1'h0, "irq masked");
	ck(host_status, 4'hB, "status");
	ck(cfg_via_host_reg, 1'h0, "cfg early");
	ck(n_sym, 8'h08, "voc symbols");
	settle;
	ck(host_irq, 1'h1, "irq");
	host_status_read = 1'h1;
	@(negedge ref_clk);
	host_status_read = 1'h0;
	@(negedge ref_clk);
	ck(host_irq, 1'h0, "irq clear");
	lfsr = rnd(lfsr);
	for (i = 0; i < 8; i = i + 1)
		sym(4'h0, lfsr[7 - i]);
	rx_voice_valid = 1'h0;
	ck({host_voice_valid, host_voice_byte}, {1'h1, lfsr[7:0]}, "hard byte");
	host_tx_voice_valid = 1'h1;
	host_tx_voice_bit = lfsr[8];
	@(negedge ref_clk);
	ck({tx_voice_valid, tx_voice_bit}, {1'h1, lfsr[8]}, "host tx");
	host_tx_voice_valid = 1'h0;
	host_cfg_soft = 1'h1;
	settle;
	sym(lfsr[3:0], 1'h0);
	sym(lfsr[7:4], 1'h0);
	rx_voice_valid = 1'h0;
	ck({host_voice_valid, host_voice_byte}, {1'h1, lfsr[3:0], lfsr[7:4]}, "soft byte");
	ck(n_sym, 8'h08, "voc idle");
	wrap_up;
end
endmodule
bind pfv_fec_route pfv_chk #(.LATENCY_CYCLES(LATENCY_CYCLES)) chk (
	.ref_clk(ref_clk),
	.reset(reset),
	.host_status(host_status),
	.host_irq(host_irq),
	.host_cfg_irq_mask(host_cfg_irq_mask),
	.cfg_soft_reg(cfg_soft_reg),
	.cfg_via_host_reg(cfg_via_host_reg),
	.rx_mi_valid(rx_mi_valid),
	.host_mi_valid(host_mi_valid),
	.host_mi_crc_fail(host_mi_crc_fail),
	.call_accept(call_accept),
	.call_reject(call_reject),
	.host_tx_mi_valid(host_tx_mi_valid),
	.tx_mi_valid(tx_mi_valid),
	.tx_mi_copy_zero(tx_mi_copy_zero),
	.tx_mi_copy_one(tx_mi_copy_one),
	.rx_voice_valid(rx_voice_valid),
	.rx_voice_llr(rx_voice_llr),
	.voc_rx_valid(voc_rx_valid),
	.voc_rx_llr(voc_rx_llr)
);
